// ==== hw/hsfi_pkg.sv ====
// shared constants and types of the host serial frame interface
package hsfi_pkg;

	// --------------------------------
	// clocking and link timing
	// --------------------------------
	localparam int unsigned CLOCK_HZ       = 250_000_000;
	localparam int unsigned UART_BAUD      = 57600;
	localparam int unsigned ETU_CYCLES_DEF = CLOCK_HZ / UART_BAUD;
	localparam logic [3:0]  UART_SLOTS     = 4'hb;  // start, 8 data, 2 stop
	localparam logic [3:0]  UART_STOP_SLOT = 4'h9;
	localparam logic [2:0]  SEL_SETTLE     = 3'h7;

	// --------------------------------
	// synchronised pin vector layout and reset values
	// --------------------------------
	localparam int         PIN_SCK  = 5;
	localparam int         PIN_SS   = 4;
	localparam int         PIN_MOSI = 3;
	localparam int         PIN_RX   = 2;
	localparam int         PIN_SELA = 1;
	localparam int         PIN_SELB = 0;
	localparam logic [5:0] PIN_RST  = 6'h14;   // ss high, rx high

	// --------------------------------
	// control bytes, echo and flags
	// --------------------------------
	localparam logic [7:0] CTRL_SEND      = 8'h00;
	localparam logic [7:0] CTRL_RESET     = 8'h01;
	localparam logic [7:0] CTRL_READ      = 8'h02;
	localparam logic [7:0] CTRL_POLL      = 8'h03;
	localparam logic [7:0] ECHO_BYTE      = 8'h55;
	localparam logic [7:0] FLAG_READ_MASK = 8'h08;
	localparam logic [7:0] FLAG_SEND_MASK = 8'h04;

	// --------------------------------
	// reply codes and long-frame layout
	// --------------------------------
	localparam logic [7:0] CODE_FRAME_OK     = 8'h80;
	localparam logic [7:0] CODE_WAIT_TIMEOUT = 8'h87;
	localparam logic [7:0] CODE_BAD_SOF      = 8'h88;
	localparam logic [7:0] CODE_OVERFLOW     = 8'h89;
	localparam logic [7:0] CODE_FRAMING      = 8'h8a;
	localparam logic [7:0] CODE_SHORT_LEN    = 8'h8c;
	localparam logic [7:0] CODE_CHECKSUM     = 8'h8d;
	localparam logic [7:0] CODE_LOST         = 8'h8e;
	localparam logic [7:0] CODE_RESIDUAL     = 8'h90;
	localparam logic [7:0] CODE_IBUF_FULL    = CODE_OVERFLOW;
	localparam logic [9:0] RX_LIMIT_TYPE_A   = 10'h100;  // 256 bytes
	localparam logic [9:0] RX_LIMIT_LONG     = 10'h210;  // 528 bytes
	localparam logic [9:0] SYNC_LOSS_LIMIT   = 10'h210;  // 528 bytes
	localparam int         BUF_DEPTH         = 528;

	// --------------------------------
	// reply kinds given by the core and transaction phases
	// --------------------------------
	typedef enum logic [3:0] {
		KIND_OK, KIND_TIMEOUT, KIND_OVERFLOW, KIND_FRAMING, KIND_BAD_SOF,
		KIND_LOST, KIND_RESIDUAL, KIND_SHORT_LEN, KIND_CHECKSUM
	} hsfi_kind_type;

	typedef enum logic [2:0] {
		SP_CTRL, SP_SEND, SP_POLL, SP_READ, SP_IGNORE
	} hsfi_spi_type;

	typedef enum logic [1:0] {
		PA_CMD, PA_LEN, PA_DATA
	} hsfi_par_type;

endpackage : hsfi_pkg

// ==== hw/hsfi_mem.sv ====
// reply data buffer with registered read port
`timescale 1ns/1ps
`default_nettype none
module hsfi_mem
	import hsfi_pkg::*;
(
	// clock
	input  wire logic       clock_in,
	// write port from the core
	input  wire logic       wr_en_in,
	input  wire logic [9:0] wr_addr_in,
	input  wire logic [7:0] wr_data_in,
	// read port
	input  wire logic [9:0] rd_addr_in,
	output var  logic [7:0] rd_data_out
);

	// --------------------------------
	// storage
	// --------------------------------
	logic [7:0] mem_r [0:BUF_DEPTH-1];

	// writes beyond the buffer are dropped
	always_ff @(posedge clock_in) begin
		if (wr_en_in && (wr_addr_in < 10'(BUF_DEPTH))) begin
			mem_r[wr_addr_in] <= wr_data_in;
		end
	end

	// registered read, out of range reads give zero
	always_ff @(posedge clock_in) begin
		if (rd_addr_in < 10'(BUF_DEPTH)) begin
			rd_data_out <= mem_r[rd_addr_in];
		end else begin
			rd_data_out <= 8'h00;
		end
	end

endmodule : hsfi_mem
`default_nettype wire

// ==== hw/hsfi_top.sv ====
// host serial frame interface: spi slave, uart link and reply framing
//
// Behaviour
// RULE1 - uart characters go lsb first with a two-etu stop bit
// RULE2 - the low pulse that wakes the device is never a start bit
// RULE3 - 528 uart bytes without a reply give an input-buffer-full code
// RULE4 - control byte 00 sends, 03 polls, 02 reads reply data
// RULE5 - slave select high: master data ignored, miso not driven
// RULE6 - poll flags: bit 3 reply readable, bit 2 command accepted
// RULE7 - mosi sampled on rising serial clock edges
// RULE8 - host raises slave select between transactions and after reads
// RULE9 - poll keeps returning the current flags while select stays low
// RULE10 - host may abandon a poll and poll again later
// RULE11 - after reset a command is accepted without polling first
// RULE12 - control byte 01 resets core into power-up at select release
// RULE13 - spi bytes shift most significant bit first
// RULE14 - reply-request pin low from reply ready until it is read
// RULE15 - host reads only after learning a reply is available
// RULE16 - codes 80 ok, 87 timeout, 89 overflow, 8a framing fault
// RULE17 - codes 88 bad start, 8e reception lost, 90 residual bits
// RULE18 - peer protocol: 8c short length, 8d checksum fault
// RULE19 - reply limit 528 bytes long frames, 256 bytes type a
// RULE20 - long code: bit7 set, bits6:5 length high, bit4 residual
// RULE21 - data count is ten bits, length byte is the low part
// RULE22 - frames are command, length, 0 to 253 data; echo is one byte
// RULE23 - echo byte 55 is answered with the single byte 55
// RULE24 - selects 00 choose uart, select a high alone chooses spi
// RULE25 - miso filler bytes are don't care and never acted on
// RULE26 - a send captures exactly the announced number of data bytes
`timescale 1ns/1ps
`default_nettype none
module hsfi_top
	import hsfi_pkg::*;
#(
	parameter int unsigned ETU_CYCLES = ETU_CYCLES_DEF
)(
	// clock and reset
	input  wire logic          clock_in,
	input  wire logic          sys_rst_in,
	// host pins
	input  wire logic          spi_sck_in,
	input  wire logic          spi_ss_n_in,
	input  wire logic          spi_mosi_in,
	input  wire logic          rx_wake_n_in,
	input  wire logic          interface_select_a_in,
	input  wire logic          interface_select_b_in,
	output var  logic          spi_miso_out,
	output var  logic          spi_miso_oe_out,
	output var  logic          tx_irq_n_out,
	// command stream to the core
	output var  logic [7:0]    cmd_data_out,
	output var  logic          cmd_valid_out,
	output var  logic          cmd_first_out,
	output var  logic          cmd_last_out,
	output var  logic          core_reset_out,
	output var  logic          wait_for_event_state_out,
	// reply from the core
	input  wire logic          rsp_valid_in,
	input  wire hsfi_kind_type rsp_kind_in,
	input  wire logic [9:0]    rsp_len_in,
	input  wire logic          rsp_residual_in,
	input  wire logic          rsp_type_a_in,
	input  wire logic          rsp_wr_en_in,
	input  wire logic [9:0]    rsp_wr_addr_in,
	input  wire logic [7:0]    rsp_wr_data_in
);

	// --------------------------------
	// helpers
	// --------------------------------
	localparam logic [15:0] ETU_M1   = 16'(ETU_CYCLES - 1);
	localparam logic [15:0] ETU_HALF = 16'(ETU_CYCLES / 2);

	// maps a core outcome onto the reply code byte
	function automatic logic [7:0] reply_code_of(
		input hsfi_kind_type kind,
		input logic [9:0]    len,
		input logic          residual
	);
		logic [7:0] code;
		code = CODE_FRAME_OK;
		unique case (kind)
			// RULE20 long frame code
			KIND_OK:        code = {1'b1, len[9:8], residual, 4'h0};
			// RULE16 core error codes
			KIND_TIMEOUT:   code = CODE_WAIT_TIMEOUT;
			KIND_OVERFLOW:  code = CODE_OVERFLOW;
			KIND_FRAMING:   code = CODE_FRAMING;
			// RULE17 frame fault codes
			KIND_BAD_SOF:   code = CODE_BAD_SOF;
			KIND_LOST:      code = CODE_LOST;
			KIND_RESIDUAL:  code = CODE_RESIDUAL;
			// RULE18 peer protocol codes
			KIND_SHORT_LEN: code = CODE_SHORT_LEN;
			KIND_CHECKSUM:  code = CODE_CHECKSUM;
			default:        code = CODE_FRAME_OK;
		endcase
		return code;
	endfunction : reply_code_of

	// --------------------------------
	// declarations
	// --------------------------------
	logic [5:0]   p1_r, p2_r, p3_r, pf_r, pfd_r;
	logic         mode_spi_r, mode_uart_r, wfe_r, rst_pend_r;
	logic [2:0]   cap_cnt_r, bit_cnt_r;
	hsfi_spi_type ph_r;
	hsfi_par_type par_r;
	logic [7:0]   rx_sh_r, tx_sh_r, dcnt_r, code_r;
	logic         pend_r, echo_r, done_read_r, rd_ok_r, busy_r, miso_oe_r;
	logic [9:0]   len_r, cnt_r, loss_cnt_r;
	logic         ur_busy_r, ur_arm_r, ur_valid_r, tx_irq_r;
	logic [15:0]  ur_tmr_r, ut_tmr_r;
	logic [3:0]   ur_bit_r, ut_n_r;
	logic [7:0]   ur_sh_r, ur_data_r, mem_q;
	logic [10:0]  ut_sh_r;
	logic [7:0]   cmd_data_r;
	logic         cmd_valid_r, cmd_first_r, cmd_last_r, core_rst_r;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	wire logic [5:0] pins_raw = {spi_sck_in, spi_ss_n_in, spi_mosi_in,
		rx_wake_n_in, interface_select_a_in, interface_select_b_in};
	wire logic [5:0] agree    = ~(p2_r ^ p3_r);
	wire logic [5:0] pf_nxt   = (agree & p3_r) | (~agree & pf_r);

	// a level counts only once stages two and three agree
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			p1_r  <= PIN_RST;
			p2_r  <= PIN_RST;
			p3_r  <= PIN_RST;
			pf_r  <= PIN_RST;
			pfd_r <= PIN_RST;
		end else begin
			p1_r  <= pins_raw;
			p2_r  <= p1_r;
			p3_r  <= p2_r;
			pf_r  <= pf_nxt;
			pfd_r <= pf_r;
		end
	end

	// ----------------------------------------------------------------
	// decode of spi events and reply byte selection
	// ----------------------------------------------------------------
	// RULE5 select gates the port
	wire logic spi_act   = mode_spi_r & ~wfe_r & ~pf_r[PIN_SS];
	// RULE7 rising clock samples
	wire logic sck_rise  = pf_r[PIN_SCK] & ~pfd_r[PIN_SCK];
	wire logic sck_fall  = ~pf_r[PIN_SCK] & pfd_r[PIN_SCK];
	wire logic ss_fall   = ~pf_r[PIN_SS] & pfd_r[PIN_SS];
	wire logic ss_rise   = pf_r[PIN_SS] & ~pfd_r[PIN_SS] & mode_spi_r;
	wire logic byte_done = spi_act & sck_rise & (bit_cnt_r == 3'h7);
	// RULE13 msb arrives first
	wire logic [7:0] rx_byte = {rx_sh_r[6:0], pf_r[PIN_MOSI]};
	// RULE12 reset waits for select release
	wire logic reset_do  = ss_rise & rst_pend_r;
	// RULE6 flag byte
	wire logic [7:0] flags = (pend_r ? FLAG_READ_MASK : 8'h00)
		| ((~busy_r & ~pend_r) ? FLAG_SEND_MASK : 8'h00);
	wire logic [9:0] tot = echo_r ? 10'h001 : 10'(len_r + 10'h002);
	wire logic [7:0] rsp_byte = (cnt_r == 10'h000)
		? (echo_r ? ECHO_BYTE : code_r)
		: ((cnt_r == 10'h001) ? len_r[7:0] : mem_q);
	// RULE4 control byte selects the phase
	wire logic ctrl_read = (ph_r == SP_CTRL) & (rx_byte == CTRL_READ);
	wire logic spi_take  = byte_done & ~done_read_r
		& (ctrl_read | (ph_r == SP_READ));
	wire logic uart_take = mode_uart_r & ~wfe_r & pend_r & ~done_read_r
		& rd_ok_r & (ut_n_r == 4'h0);
	wire logic rsp_take  = spi_take | uart_take;
	wire logic last_take = rsp_take & (10'(cnt_r + 10'h001) == tot);
	// RULE14 request lasts until the read completes
	wire logic spi_done  = ss_rise & done_read_r;
	wire logic uart_done = mode_uart_r & pend_r & done_read_r
		& (ut_n_r == 4'h0);
	wire logic pend_clr  = spi_done | uart_done | reset_do;

	// ----------------------------------------------------------------
	// host byte stream and reply setting
	// ----------------------------------------------------------------
	// RULE25 only send-phase spi bytes and uart bytes reach the parser
	wire logic hb_valid  = (byte_done & (ph_r == SP_SEND))
		| (ur_valid_r & mode_uart_r);
	wire logic [7:0] hb_data = byte_done ? rx_byte : ur_data_r;
	// RULE23 echo answered at once
	wire logic echo_hit  = hb_valid & (par_r == PA_CMD)
		& (hb_data == ECHO_BYTE);
	// RULE3 sync loss bound
	wire logic loss_hit  = ur_valid_r & mode_uart_r & ~echo_hit
		& (loss_cnt_r == 10'(SYNC_LOSS_LIMIT - 10'h001));
	wire logic rsp_set   = rsp_valid_in | echo_hit | loss_hit;
	wire logic par_abort = ss_rise | reset_do | loss_hit;
	// last byte of a host frame, only on a real byte
	wire logic cmd_last_nxt = hb_valid & ~echo_hit & ~loss_hit
		& (((par_r == PA_LEN) & (hb_data == 8'h00))
		| ((par_r == PA_DATA) & (dcnt_r == 8'h01)));
	// RULE19 length bound per card family
	wire logic over      = rsp_len_in
		> (rsp_type_a_in ? RX_LIMIT_TYPE_A : RX_LIMIT_LONG);
	wire logic has_data  = ~over
		& ((rsp_kind_in == KIND_OK) | (rsp_kind_in == KIND_RESIDUAL));
	wire logic [7:0] core_code = over ? CODE_OVERFLOW
		: reply_code_of(rsp_kind_in, rsp_len_in, rsp_residual_in);

	// ----------------------------------------------------------------
	// mode, wait-for-event state and spi reset
	// ----------------------------------------------------------------
	// RULE11 powers up ready, RULE24 selects sampled after settling
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			wfe_r       <= 1'b0;
			cap_cnt_r   <= 3'h0;
			mode_spi_r  <= 1'b0;
			mode_uart_r <= 1'b0;
			rst_pend_r  <= 1'b0;
			core_rst_r  <= 1'b0;
		end else begin
			core_rst_r <= reset_do;
			if (reset_do) begin
				wfe_r <= 1'b1;
			end else if (wfe_r && !pf_r[PIN_RX]) begin
				wfe_r     <= 1'b0;
				cap_cnt_r <= 3'h0;
			end else if (cap_cnt_r != SEL_SETTLE) begin
				cap_cnt_r   <= cap_cnt_r + 3'h1;
				mode_spi_r  <= pf_r[PIN_SELA] & ~pf_r[PIN_SELB];
				mode_uart_r <= ~pf_r[PIN_SELA] & ~pf_r[PIN_SELB];
			end
			if (ss_rise) begin
				rst_pend_r <= 1'b0;
			end else if (byte_done && ph_r == SP_CTRL
					&& rx_byte == CTRL_RESET) begin
				rst_pend_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// spi shifter
	// ----------------------------------------------------------------
	wire logic [7:0] ctrl_tx = (rx_byte == CTRL_POLL) ? flags
		: ((rx_byte == CTRL_READ) ? rsp_byte : 8'h00);
	wire logic [7:0] tx_load = (ph_r == SP_CTRL) ? ctrl_tx
		: ((ph_r == SP_POLL) ? flags
		: ((ph_r == SP_READ) ? rsp_byte : 8'h00));
	wire hsfi_spi_type ph_ctrl = (rx_byte == CTRL_SEND) ? SP_SEND
		: ((rx_byte == CTRL_POLL) ? SP_POLL
		: ((rx_byte == CTRL_READ) ? SP_READ : SP_IGNORE));

	// a byte is loaded on the eighth rising edge, shifted on falls
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ph_r      <= SP_CTRL;
			bit_cnt_r <= 3'h0;
			rx_sh_r   <= 8'h00;
			tx_sh_r   <= 8'h00;
			miso_oe_r <= 1'b0;
		end else begin
			miso_oe_r <= spi_act;
			if (ss_fall || ss_rise) begin
				ph_r      <= SP_CTRL;
				bit_cnt_r <= 3'h0;
				tx_sh_r   <= 8'h00;
			end else if (spi_act && sck_rise) begin
				rx_sh_r   <= rx_byte;
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (byte_done) begin
					// RULE9 poll reloads the live flags
					tx_sh_r <= tx_load;
					if (ph_r == SP_CTRL) begin
						ph_r <= ph_ctrl;
					end
				end
			end else if (spi_act && sck_fall && bit_cnt_r != 3'h0) begin
				// RULE13 msb leaves first
				tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// reply state
	// ----------------------------------------------------------------
	// a new reply wins over a clear in the same cycle
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			pend_r      <= 1'b0;
			echo_r      <= 1'b0;
			code_r      <= 8'h00;
			len_r       <= 10'h000;
			cnt_r       <= 10'h000;
			done_read_r <= 1'b0;
			rd_ok_r     <= 1'b0;
			busy_r      <= 1'b0;
			loss_cnt_r  <= 10'h000;
		end else begin
			rd_ok_r <= ~rsp_take;
			if (rsp_set) begin
				pend_r      <= 1'b1;
				cnt_r       <= 10'h000;
				done_read_r <= 1'b0;
				echo_r      <= echo_hit & ~loss_hit;
				// RULE3 input buffer full reply
				if (loss_hit) begin
					code_r <= CODE_IBUF_FULL;
					len_r  <= 10'h000;
				end else if (!echo_hit) begin
					code_r <= core_code;
					// RULE21 ten bit count kept whole
					len_r  <= has_data ? rsp_len_in : 10'h000;
				end
			end else if (pend_clr) begin
				pend_r      <= 1'b0;
				cnt_r       <= 10'h000;
				done_read_r <= 1'b0;
			end else if (rsp_take) begin
				if (last_take) begin
					done_read_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 10'h001;
				end
			end
			if (hb_valid && cmd_last_nxt) begin
				busy_r <= 1'b1;
			end else if (rsp_valid_in || reset_do) begin
				busy_r <= 1'b0;
			end
			if (rsp_set || reset_do) begin
				loss_cnt_r <= 10'h000;
			end else if (ur_valid_r && mode_uart_r) begin
				loss_cnt_r <= loss_cnt_r + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// command frame parser
	// ----------------------------------------------------------------
	// RULE22 command, length, data; RULE26 exact data count
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			par_r       <= PA_CMD;
			dcnt_r      <= 8'h00;
			cmd_data_r  <= 8'h00;
			cmd_valid_r <= 1'b0;
			cmd_first_r <= 1'b0;
			cmd_last_r  <= 1'b0;
		end else begin
			cmd_valid_r <= hb_valid & ~echo_hit & ~loss_hit;
			cmd_data_r  <= hb_data;
			cmd_first_r <= hb_valid & ~echo_hit & ~loss_hit
				& (par_r == PA_CMD);
			cmd_last_r  <= cmd_last_nxt;
			if (par_abort) begin
				par_r <= PA_CMD;
			end else if (hb_valid && !echo_hit) begin
				unique case (par_r)
					PA_CMD: par_r <= PA_LEN;
					PA_LEN: begin
						dcnt_r <= hb_data;
						par_r  <= (hb_data == 8'h00) ? PA_CMD : PA_DATA;
					end
					PA_DATA: begin
						dcnt_r <= dcnt_r - 8'h01;
						par_r  <= (dcnt_r == 8'h01) ? PA_CMD : PA_DATA;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// uart receiver and transmitter
	// ----------------------------------------------------------------
	wire logic ur_start = ~ur_busy_r & ur_arm_r & mode_uart_r & ~wfe_r
		& ~pf_r[PIN_RX] & pfd_r[PIN_RX];

	// RULE2 line must go high after wake before a start counts
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ur_arm_r   <= 1'b0;
			ur_busy_r  <= 1'b0;
			ur_tmr_r   <= 16'h0000;
			ur_bit_r   <= 4'h0;
			ur_sh_r    <= 8'h00;
			ur_data_r  <= 8'h00;
			ur_valid_r <= 1'b0;
		end else begin
			ur_arm_r   <= wfe_r ? 1'b0 : (pf_r[PIN_RX] | ur_arm_r);
			ur_valid_r <= 1'b0;
			if (ur_start) begin
				ur_busy_r <= 1'b1;
				ur_tmr_r  <= ETU_HALF;
				ur_bit_r  <= 4'h0;
			end else if (ur_busy_r && ur_tmr_r != 16'h0000) begin
				ur_tmr_r <= ur_tmr_r - 16'h0001;
			end else if (ur_busy_r) begin
				ur_tmr_r <= ETU_M1;
				ur_bit_r <= ur_bit_r + 4'h1;
				// RULE1 lsb first, stop must read high
				if (ur_bit_r == 4'h0 && pf_r[PIN_RX]) begin
					ur_busy_r <= 1'b0;
				end else if (ur_bit_r == UART_STOP_SLOT) begin
					ur_busy_r  <= 1'b0;
					ur_valid_r <= pf_r[PIN_RX];
					ur_data_r  <= ur_sh_r;
				end else if (ur_bit_r != 4'h0) begin
					ur_sh_r <= {pf_r[PIN_RX], ur_sh_r[7:1]};
				end
			end
		end
	end

	// RULE1 start, eight data lsb first, two stop slots
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ut_sh_r  <= 11'h7ff;
			ut_n_r   <= 4'h0;
			ut_tmr_r <= 16'h0000;
		end else if (uart_take) begin
			ut_sh_r  <= {2'b11, rsp_byte, 1'b0};
			ut_n_r   <= UART_SLOTS;
			ut_tmr_r <= ETU_M1;
		end else if (ut_n_r != 4'h0 && ut_tmr_r != 16'h0000) begin
			ut_tmr_r <= ut_tmr_r - 16'h0001;
		end else if (ut_n_r != 4'h0) begin
			ut_tmr_r <= ETU_M1;
			ut_sh_r  <= {1'b1, ut_sh_r[10:1]};
			ut_n_r   <= ut_n_r - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// shared pin, buffer and output registers
	// ----------------------------------------------------------------
	// RULE14 pin is the request in spi, transmit data in uart
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			tx_irq_r <= 1'b1;
		end else if (mode_spi_r) begin
			tx_irq_r <= ~pend_r;
		end else begin
			tx_irq_r <= (ut_n_r == 4'h0) | ut_sh_r[0];
		end
	end

	// data bytes follow the code and length bytes
	hsfi_mem u_mem (
		.clock_in    (clock_in),
		.wr_en_in    (rsp_wr_en_in),
		.wr_addr_in  (rsp_wr_addr_in),
		.wr_data_in  (rsp_wr_data_in),
		.rd_addr_in  (10'(cnt_r - 10'h002)),
		.rd_data_out (mem_q)
	);

	assign spi_miso_out             = tx_sh_r[7];
	assign spi_miso_oe_out          = miso_oe_r;
	assign tx_irq_n_out             = tx_irq_r;
	assign cmd_data_out             = cmd_data_r;
	assign cmd_valid_out            = cmd_valid_r;
	assign cmd_first_out            = cmd_first_r;
	assign cmd_last_out             = cmd_last_r;
	assign core_reset_out           = core_rst_r;
	assign wait_for_event_state_out = wfe_r;

endmodule : hsfi_top
`default_nettype wire

// ==== tb/hsfi_assertions.sv ====
// port-level checks of the host serial frame interface
`timescale 1ns/1ps
`default_nettype none
module hsfi_assertions (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// watched pins
	input wire logic spi_ss_n_in,
	input wire logic rsp_valid_in,
	input wire logic spi_miso_oe_out,
	input wire logic tx_irq_n_out,
	input wire logic cmd_valid_out,
	input wire logic cmd_first_out,
	input wire logic core_reset_out,
	input wire logic wait_for_event_state_out
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	miso_release_a: assert property (
		spi_ss_n_in [*8] |-> !spi_miso_oe_out) else $error("miso driven");
	irq_request_a: assert property (
		rsp_valid_in |-> ##2 !tx_irq_n_out) else $error("no reply request");
	irq_hold_a: assert property (
		spi_ss_n_in [*8] ##0 !tx_irq_n_out |=> !tx_irq_n_out)
		else $error("request dropped unread");
	cmd_pulse_a: assert property (
		cmd_valid_out |=> !cmd_valid_out) else $error("byte pulse too long");
	first_valid_a: assert property (
		cmd_first_out |-> cmd_valid_out) else $error("stray first mark");
	cmd_selected_a: assert property (
		cmd_valid_out |-> !$past(spi_ss_n_in, 4)) else $error("byte unselected");
	reset_pulse_a: assert property (
		core_reset_out |-> $past(spi_ss_n_in, 3)
		##1 (!core_reset_out && wait_for_event_state_out))
		else $error("bad core reset");
	wait_quiet_a: assert property (
		wait_for_event_state_out [*2] |-> !spi_miso_oe_out)
		else $error("miso driven asleep");
endmodule : hsfi_assertions
`default_nettype wire

// ==== tb/hsfi_host.sv ====
// host model: spi master pins with byte and select tasks
`timescale 1ns/1ps
`default_nettype none
module hsfi_host (
	// spi master pins
	output var  logic sck_out,
	output var  logic ss_n_out,
	output var  logic mosi_out,
	input  wire logic miso_in
);
	// clock parked low and device deselected outside frames
	initial begin
		sck_out = 1'b0;
		ss_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// select moves half a period clear of the clock
	task automatic sel(input logic v);
		#24 ss_n_out = v;
		#24 mosi_out = ~mosi_out;
	endtask : sel
	// msb first, both sides take data on rising sck
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_out = tx[i];
			#24 sck_out = 1'b1;
			rx[i] = miso_in;
			#24 sck_out = 1'b0;
		end
	endtask : xfer
endmodule : hsfi_host
`default_nettype wire

// ==== tb/hsfi_top_tb.sv ====
// self-checking spi bench of the host serial frame interface
`timescale 1ns/1ps
`default_nettype none
module hsfi_top_tb;
	import hsfi_pkg::*;
	logic clock_in, sys_rst_in, spi_sck_in, spi_ss_n_in, spi_mosi_in;
	logic rx_wake_n_in, interface_select_a_in, interface_select_b_in;
	logic spi_miso_out, spi_miso_oe_out, tx_irq_n_out, cmd_valid_out;
	logic cmd_first_out, cmd_last_out, core_reset_out, rsp_type_a_in;
	logic wait_for_event_state_out, rsp_valid_in, rsp_residual_in;
	logic rsp_wr_en_in;
	logic [7:0] cmd_data_out, rsp_wr_data_in, d [528];
	logic [9:0] rsp_len_in, rsp_wr_addr_in, q [$];
	hsfi_kind_type rsp_kind_in;
	int seed = 32'hb6e9;
	int fail_count = 0;
	int n_tests = 0;
	int resets = 0;
	// short bit time; the uart side stays idle in this bench
	hsfi_top #(.ETU_CYCLES(8)) hsfi_top_inst (.*);
	hsfi_host hsfi_host_inst (.sck_out(spi_sck_in), .ss_n_out(spi_ss_n_in),
		.mosi_out(spi_mosi_in), .miso_in(spi_miso_out));
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	// hang guard, about twice the expected run
	initial begin
		#400000;
		fail_count++;
		stop_test();
	end
	// log command bytes and core resets
	always @(posedge clock_in) begin
		if (cmd_valid_out)
			q.push_back({cmd_first_out, cmd_last_out, cmd_data_out});
		if (core_reset_out)
			resets++;
	end
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	// code and data count the host should read back
	function automatic logic [17:0] rep(hsfi_kind_type k, logic [9:0] n,
		logic a);
		logic [7:0] t [9] = '{CODE_FRAME_OK, CODE_WAIT_TIMEOUT,
			CODE_OVERFLOW, CODE_FRAMING, CODE_BAD_SOF, CODE_LOST,
			CODE_RESIDUAL, CODE_SHORT_LEN, CODE_CHECKSUM};
		if (k == KIND_OK && n > (a ? RX_LIMIT_TYPE_A : RX_LIMIT_LONG))
			return {CODE_OVERFLOW, 10'h000};
		if (k == KIND_OK)
			return {1'b1, n[9:8], n[0], 4'h0, n};
		return {t[k], k == KIND_RESIDUAL ? n : 10'h000};
	endfunction : rep
	task automatic open(input logic [7:0] ctrl);
		logic [7:0] r;
		hsfi_host_inst.sel(1'b0);
		hsfi_host_inst.xfer(ctrl, r);
	endtask : open
	// let the select synchroniser settle before looking
	task automatic close();
		hsfi_host_inst.sel(1'b1);
		repeat (8) @(negedge clock_in);
	endtask : close
	// flags read twice in one poll
	task automatic poll(input logic [7:0] e);
		logic [7:0] r;
		open(CTRL_POLL);
		repeat (2) begin
			hsfi_host_inst.xfer(8'h00, r);
			chk(r & 8'h0c, e);
		end
		close();
	endtask : poll
	task automatic send(input logic [7:0] c, input logic [7:0] m);
		logic [7:0] r;
		open(CTRL_SEND);
		hsfi_host_inst.xfer(c, r);
		if (c != ECHO_BYTE)
			hsfi_host_inst.xfer(m, r);
		for (int i = 0; i < m; i++)
			hsfi_host_inst.xfer(d[i], r);
		close();
		chk(18'(q.size()), c == ECHO_BYTE ? 18'h0 : 18'(m) + 18'h2);
		foreach (q[i])
			chk(q[i], {i == 0, i == m + 1,
				i == 0 ? c : i == 1 ? m : d[i - 2]});
		q = {};
	endtask : send
	// core side: buffer the data, then pulse valid
	task automatic reply(input hsfi_kind_type k, input logic [9:0] n,
		input logic a);
		for (int i = 0; i < n; i++) begin
			@(negedge clock_in);
			rsp_wr_en_in = 1'b1;
			rsp_wr_addr_in = 10'(i);
			rsp_wr_data_in = d[i];
		end
		@(negedge clock_in);
		rsp_wr_en_in = 1'b0;
		rsp_kind_in = k;
		{rsp_len_in, rsp_residual_in, rsp_type_a_in} = {n, n[0], a};
		rsp_valid_in = 1'b1;
		@(negedge clock_in);
		rsp_valid_in = 1'b0;
		repeat (3) @(negedge clock_in);
		chk(tx_irq_n_out, 1'b0);
	endtask : reply
	// read only once a reply is known to wait
	task automatic rd(input logic [17:0] e);
		logic [7:0] r;
		open(CTRL_READ);
		hsfi_host_inst.xfer(8'h00, r);
		chk(r, e[17:10]);
		if (e[17:10] != ECHO_BYTE) begin
			hsfi_host_inst.xfer(8'h00, r);
			chk(r, e[7:0]);
		end
		for (int i = 0; i < e[9:0]; i++) begin
			hsfi_host_inst.xfer(8'h00, r);
			chk(r, d[i]);
		end
		close();
		chk(tx_irq_n_out, 1'b1);
	endtask : rd
	initial begin
		logic [7:0] c, m;
		logic [9:0] n;
		hsfi_kind_type k;
		{sys_rst_in, rx_wake_n_in, interface_select_a_in} = 3'b111;
		{interface_select_b_in, rsp_valid_in, rsp_wr_en_in} = 3'b000;
		{rsp_residual_in, rsp_type_a_in, rsp_len_in} = '0;
		{rsp_wr_addr_in, rsp_wr_data_in} = '0;
		rsp_kind_in = KIND_OK;
		repeat (5) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (12) @(negedge clock_in);
		poll(8'h04);
		send(ECHO_BYTE, 8'h00);
		chk(tx_irq_n_out, 1'b0);
		rd({ECHO_BYTE, 10'h000});
		$display("echo test done");
		for (int i = 0; i < 11; i++) begin
			foreach (d[j])
				d[j] = 8'($random(seed));
			c = 8'($random(seed));
			m = 8'($unsigned($random(seed)) % 6);
			send(c == ECHO_BYTE ? 8'h56 : c, m);
			poll(8'h00);
			n = i > 8 ? 10'd257 : 10'($unsigned($random(seed)) % 6);
			k = hsfi_kind_type'(i > 8 ? 0 : i);
			reply(k, n, i == 10);
			poll(8'h08);
			rd(rep(k, n, i == 10));
			poll(8'h04);
			$display("reply test %0d done", i);
		end
		open(CTRL_RESET);
		close();
		chk({resets[1:0], wait_for_event_state_out}, 3'b011);
		open(CTRL_POLL);
		close();
		rx_wake_n_in = 1'b0;
		repeat (8) @(negedge clock_in);
		rx_wake_n_in = 1'b1;
		repeat (20) @(negedge clock_in);
		chk(wait_for_event_state_out, 1'b0);
		$display("reset test done");
		stop_test();
	end
endmodule : hsfi_top_tb
// checker beside the top level, wired by port name
bind hsfi_top hsfi_assertions hsfi_assertions_inst (.*);
`default_nettype wire
